// ==== apw_pkg.sv ====
`default_nettype none
// shared constants, types and helpers for the configuration port
package apw_pkg;
  // apb address width and the bit that selects the shadow buffer
  localparam int ADDR_W = 20;
  localparam int SHADOW_BIT = 19;
  // word address taken from byte address bits 18:2
  localparam int WADDR_W = 17;
  localparam int WADDR_LSB = 2;
  localparam int DATA_W = 32;
  // wide entries span a power-of-two number of words
  localparam int SPAN_LOG2 = 2;
  localparam int WIDE_W = 128;
  localparam int PAD_W = WIDE_W - DATA_W;
  // number of wide banks, each with its own shadow buffer
  localparam int NUM_BANKS = 2;
  localparam int BANK_W = 1;
  localparam logic [WADDR_W-1:0] BANK_MASK = 17'h003ff;
  localparam logic [WADDR_W-1:0] BANK0_BASE = 17'h08000;
  localparam logic [WADDR_W-1:0] BANK1_BASE = 17'h08400;
  // internal timeout in core clock cycles
  localparam int TMO_W = 11;
  localparam logic [TMO_W-1:0] TMO_CYC = 11'h400;
  localparam logic [TMO_W-1:0] TMO_LAST = TMO_CYC - 11'h001;
  localparam logic [TMO_W-1:0] TMO_RST = 11'h000;
  // values after reset
  localparam logic [DATA_W-1:0] PRDATA_RST = 32'h00000000;
  localparam logic [WIDE_W-1:0] WIDE_RST = {WIDE_W{1'b0}};
  localparam logic [WADDR_W-1:0] WADDR_RST = 17'h00000;

  // transfer sequencer states
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_CORE = 2'b01,
    ST_DONE = 2'b10
  } apw_state_t;

  // word address falls inside the bank starting at base
  function automatic logic bank_hit(input logic [WADDR_W-1:0] a,
                                    input logic [WADDR_W-1:0] base);
    return (a & ~BANK_MASK) == base;
  endfunction

  // one 32-bit slice of a wide entry
  function automatic logic [DATA_W-1:0] word_of(
    input logic [WIDE_W-1:0] e, input logic [SPAN_LOG2-1:0] i);
    logic [WIDE_W-1:0] s;
    s = e >> {i, 5'b00000};
    return s[DATA_W-1:0];
  endfunction

  // wide entry with one slice replaced
  function automatic logic [WIDE_W-1:0] merge(
    input logic [WIDE_W-1:0] e, input logic [SPAN_LOG2-1:0] i,
    input logic [DATA_W-1:0] w);
    logic [WIDE_W-1:0] m;
    m = e & ~({{PAD_W{1'b0}}, {DATA_W{1'b1}}} << {i, 5'b00000});
    m = m | ({{PAD_W{1'b0}}, w} << {i, 5'b00000});
    return m;
  endfunction
endpackage
`default_nettype wire

// ==== apw_shadow.sv ====
`timescale 1ns/1ps
`default_nettype none
// one shadow buffer per wide bank
module apw_shadow
  import apw_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [BANK_W-1:0] load_bank,
  input wire logic [WIDE_W-1:0] load_data,
  input wire logic wr,
  input wire logic [BANK_W-1:0] wr_bank,
  input wire logic [SPAN_LOG2-1:0] wr_idx,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [BANK_W-1:0] rd_bank,
  output logic [WIDE_W-1:0] rd_entry
);
  // buffer storage, indexed by bank
  logic [WIDE_W-1:0] mem [NUM_BANKS];

  // read port, whole entry of one bank
  assign rd_entry = mem[rd_bank];

  // full load wins over a slice write to the same bank
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int b = 0; b < NUM_BANKS; b++)
        mem[b] <= WIDE_RST;
    end
    else
    begin
      for (int b = 0; b < NUM_BANKS; b++)
      begin
        if (load && load_bank == BANK_W'(b))
          mem[b] <= load_data;
        else if (wr && wr_bank == BANK_W'(b))
          mem[b] <= merge(mem[b], wr_idx, wr_data);
      end
    end
  end
endmodule
`default_nettype wire

// ==== apw_apb_cfg.sv ====
// Functional notes
// R1: address bit 19 selects shadow access
// R2: byte address, decode by word only
// R3: pready low until reply ready
// R4: internal timeout aborts with pslverr
// R5: unmapped address times out with pslverr
// R6: reply latency varies with core load
// R7: one shadow buffer per wide bank
// R8: direct read loads whole entry into shadow
// R9: shadow reads return captured entry words
// R10: shadow reads skip the core memory
// R11: shadow writes only touch the buffer
// R12: direct write merges bus word with shadow
// R13: no lock; direct write overwrites core updates
// R14: master reads wide entry low to high
// R15: master writes wide entry low to high
// R16: narrow registers use shadow flag cleared
// R17: bridges keep access order
// R18: wide entries spaced by power-of-two words
// R19: word offset picks the shadow slice
// R20: timeout is fixed, above normal latency
`timescale 1ns/1ps
`default_nettype none
module apw_apb_cfg
  import apw_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] apb_paddr,
  input wire logic apb_psel,
  input wire logic apb_penable,
  input wire logic apb_pwrite,
  input wire logic [DATA_W-1:0] apb_pwdata,
  output logic apb_pready,
  output logic [DATA_W-1:0] apb_prdata,
  output logic apb_pslverr,
  output logic cfg_req,
  output logic cfg_write,
  output logic [WADDR_W-1:0] cfg_addr,
  output logic [WIDE_W-1:0] cfg_wdata,
  input wire logic cfg_ack,
  input wire logic [WIDE_W-1:0] cfg_rdata
);
  // sequencer state
  apw_state_t state;
  apw_state_t next_state;
  // latched request
  logic req_write;
  logic req_shadow;
  logic req_hit;
  logic [BANK_W-1:0] req_bank;
  logic [SPAN_LOG2-1:0] req_idx;
  logic [WADDR_W-1:0] req_addr;
  logic [WIDE_W-1:0] req_wide;
  // cycles spent waiting on the core
  logic [TMO_W-1:0] tmo_cnt;
  // reply registers
  logic [DATA_W-1:0] rdata;
  logic slverr;

  // decode of the incoming address
  wire take;
  wire cur_shadow;
  wire [WADDR_W-1:0] cur_waddr;
  wire cur_hit0;
  wire cur_hit1;
  wire cur_hit;
  wire [BANK_W-1:0] cur_bank;
  wire [SPAN_LOG2-1:0] cur_idx;
  // shadow buffer access
  wire [BANK_W-1:0] rd_bank;
  wire [WIDE_W-1:0] shadow_entry;
  wire sh_load;
  wire sh_wr;
  // completion events
  wire local_done;
  wire core_done;
  wire tmo_end;
  wire xfer_end;
  // next values
  wire [DATA_W-1:0] next_rdata;
  wire [WIDE_W-1:0] next_wide;

  // a request is taken as soon as the slave is selected while idle
  assign take = (state == ST_IDLE) && apb_psel;
  // top bit is the shadow flag, never part of the address
  assign cur_shadow = apb_paddr[SHADOW_BIT]; // [R1]
  // byte lane bits dropped, word address decoded
  assign cur_waddr = apb_paddr[SHADOW_BIT-1:WADDR_LSB]; // [R1] [R2]
  // wide bank decode over power-of-two spaced entries
  assign cur_hit0 = bank_hit(cur_waddr, BANK0_BASE); // [R18]
  assign cur_hit1 = bank_hit(cur_waddr, BANK1_BASE); // [R18]
  assign cur_hit = cur_hit0 || cur_hit1;
  assign cur_bank = cur_hit1 ? 1'b1 : 1'b0; // [R7]
  // word offset inside the entry span
  assign cur_idx = cur_waddr[SPAN_LOG2-1:0]; // [R19]

  // read the bank being decoded while idle, else the latched one
  assign rd_bank = (state == ST_IDLE) ? cur_bank : req_bank;

  // direct read of a wide entry copies the whole entry
  assign sh_load = core_done && !req_write && req_hit; // [R8]
  // shadow write loads only the addressed slice
  assign sh_wr = take && cur_shadow && cur_hit && apb_pwrite; // [R11]

  // shadow access to a wide bank served locally without the core
  assign local_done = take && cur_shadow && cur_hit; // [R10]
  // core answered a direct access
  assign core_done = (state == ST_CORE) && !req_shadow && cfg_ack;
  // no answer within the fixed budget
  assign tmo_end = (state == ST_CORE) && !core_done
                   && (tmo_cnt == TMO_LAST); // [R4] [R20]
  // apb access phase completes
  assign xfer_end = (state == ST_DONE) && apb_psel && apb_penable;

  // read data for the reply
  assign next_rdata = local_done ? word_of(shadow_entry, cur_idx) : // [R9]
                      !core_done ? PRDATA_RST :
                      req_hit ? word_of(cfg_rdata, req_idx) :
                      cfg_rdata[DATA_W-1:0];

  // write data sent to the core
  assign next_wide = !apb_pwrite ? WIDE_RST :
                     cur_hit ? merge(shadow_entry, cur_idx, apb_pwdata) :
                     {{PAD_W{1'b0}}, apb_pwdata}; // [R12] [R16]

  // shadow buffers for all wide banks
  apw_shadow u_shadow
  (
    .core_clk(core_clk),
    .resetn(resetn),
    .load(sh_load),
    .load_bank(req_bank),
    .load_data(cfg_rdata),
    .wr(sh_wr),
    .wr_bank(cur_bank),
    .wr_idx(cur_idx),
    .wr_data(apb_pwdata),
    .rd_bank(rd_bank),
    .rd_entry(shadow_entry)
  ); // [R7]

  // sequencer transitions
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        // shadow hits finish at once, the rest wait
        if (local_done)
          next_state = ST_DONE;
        else if (take)
          next_state = ST_CORE;
      end
      ST_CORE:
      begin
        // wait for the core or give up
        if (core_done || tmo_end)
          next_state = ST_DONE; // [R3] [R6]
      end
      ST_DONE:
      begin
        // hold the reply until the master takes it
        if (xfer_end)
          next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // request latch, written once per transfer
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      req_write <= 1'b0;
      req_shadow <= 1'b0;
      req_hit <= 1'b0;
      req_bank <= '0;
      req_idx <= '0;
      req_addr <= WADDR_RST;
    end
    else if (take)
    begin
      req_write <= apb_pwrite;
      req_shadow <= cur_shadow;
      req_hit <= cur_hit;
      req_bank <= cur_bank;
      req_idx <= cur_idx;
      req_addr <= cur_waddr; // [R2]
    end
  end

  // full entry for the core, shadow filled in around the bus word
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      req_wide <= WIDE_RST;
    else if (take)
      req_wide <= next_wide; // [R12] [R13] [R15]
  end

  // timeout counter, runs only while waiting on the core
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      tmo_cnt <= TMO_RST;
    else if (state == ST_CORE)
      tmo_cnt <= tmo_cnt + 11'h001; // [R20]
    else
      tmo_cnt <= TMO_RST;
  end

  // reply data and error flag
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata <= PRDATA_RST;
      slverr <= 1'b0;
    end
    else
    begin
      if (local_done || core_done || tmo_end)
        rdata <= next_rdata;
      if (take)
        slverr <= 1'b0;
      else if (tmo_end)
        slverr <= 1'b1; // [R4] [R5]
    end
  end

  // apb answer
  assign apb_pready = (state == ST_DONE); // [R3]
  assign apb_prdata = rdata;
  assign apb_pslverr = slverr;
  // core request; unmapped shadow accesses never reach the core
  assign cfg_req = (state == ST_CORE) && !req_shadow; // [R5] [R11]
  assign cfg_write = req_write;
  assign cfg_addr = req_addr;
  assign cfg_wdata = req_wide;

  // pready stays low the cycle after a core access is taken
  property p_wait_low;
    @(posedge core_clk) disable iff (!resetn)
    (take && !local_done) |=> !apb_pready;
  endproperty
  a_wait_low: assert property (p_wait_low) // [R3]
    else $error("pready high while waiting on core");

  // timeout ends in an error reply next cycle
  property p_tmo_err;
    @(posedge core_clk) disable iff (!resetn)
    (state == ST_CORE && tmo_cnt == TMO_LAST && !cfg_ack)
      |=> (apb_pready && apb_pslverr);
  endproperty
  a_tmo_err: assert property (p_tmo_err) // [R4]
    else $error("timeout did not raise pslverr");

  // unmapped shadow access waits without a core request
  property p_unmapped;
    @(posedge core_clk) disable iff (!resetn)
    (take && cur_shadow && !cur_hit)
      |=> (state == ST_CORE && !cfg_req)[*8];
  endproperty
  a_unmapped: assert property (p_unmapped) // [R5]
    else $error("unmapped shadow access not held");

  // core answer gives a clean reply
  property p_core_ok;
    @(posedge core_clk) disable iff (!resetn)
    core_done |=> (apb_pready && !apb_pslverr);
  endproperty
  a_core_ok: assert property (p_core_ok) // [R6]
    else $error("core reply not passed on");

  // direct read copies the whole entry
  property p_load;
    @(posedge core_clk) disable iff (!resetn)
    sh_load |=> (shadow_entry == $past(cfg_rdata));
  endproperty
  a_load: assert property (p_load) // [R8]
    else $error("shadow not loaded by direct read");

  // shadow read returns the buffered slice with no wait
  property p_sh_read;
    @(posedge core_clk) disable iff (!resetn)
    (local_done && !apb_pwrite) |=> (apb_pready
      && apb_prdata == word_of($past(shadow_entry), $past(cur_idx)));
  endproperty
  a_sh_read: assert property (p_sh_read) // [R9]
    else $error("shadow read slice wrong");

  // shadow traffic never reaches the core
  property p_no_core;
    @(posedge core_clk) disable iff (!resetn)
    (take && cur_shadow) |=> !cfg_req;
  endproperty
  a_no_core: assert property (p_no_core) // [R11]
    else $error("shadow access sent to core");

  // direct wide write merges shadow and bus word
  property p_merge;
    @(posedge core_clk) disable iff (!resetn)
    (take && !cur_shadow && cur_hit && apb_pwrite) |=> (cfg_wdata
      == merge($past(shadow_entry), $past(cur_idx), $past(apb_pwdata)));
  endproperty
  a_merge: assert property (p_merge) // [R12]
    else $error("wide write data not merged");

  // shadow flag never reaches the word address
  property p_addr;
    @(posedge core_clk) disable iff (!resetn)
    take |=> (cfg_addr == $past(apb_paddr[SHADOW_BIT-1:WADDR_LSB]));
  endproperty
  a_addr: assert property (p_addr) // [R2]
    else $error("word address latched wrong");
endmodule
`default_nettype wire

// ==== apw_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// behavioural core side: answers direct requests after lat cycles
module apw_core_model
  import apw_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cfg_req,
  input wire logic cfg_write,
  input wire logic [WADDR_W-1:0] cfg_addr,
  input wire logic [WIDE_W-1:0] cfg_wdata,
  input wire logic [11:0] lat,
  output logic cfg_ack,
  output logic [WIDE_W-1:0] cfg_rdata
);
  // entries keyed by word address, one key per wide entry
  logic [WIDE_W-1:0] mem [logic [WADDR_W-1:0]];
  logic [11:0] cnt;
  logic done;
  wire logic wide = cfg_addr[16:11] == 6'h10;
  wire logic mapped = wide || (cfg_addr < 17'h00100);
  wire logic [WADDR_W-1:0] k = wide ? {cfg_addr[16:2], 2'b00} : cfg_addr;
  // entry as the core holds it, zero when never written
  function automatic logic [WIDE_W-1:0] peek(input logic [WADDR_W-1:0] a);
    return mem.exists(a) ? mem[a] : '0;
  endfunction
  // core updating an entry on its own
  task automatic poke(input logic [WADDR_W-1:0] a,
                      input logic [WIDE_W-1:0] d);
    mem[a] = d;
  endtask
  // one ack pulse per request; unmapped addresses never answer
  always @(posedge core_clk or negedge resetn)
  begin
    cfg_ack <= 1'b0;
    cfg_rdata <= ~cfg_rdata;
    if (!resetn)
    begin
      cnt <= '0;
      done <= 1'b0;
      cfg_rdata <= '0;
    end
    else if (!cfg_req)
    begin
      cnt <= '0;
      done <= 1'b0;
    end
    else if (!done && mapped && cnt < lat)
      cnt <= cnt + 12'h001;
    else if (!done && mapped)
    begin
      cfg_ack <= 1'b1;
      done <= 1'b1;
      cfg_rdata <= peek(k);
      if (cfg_write)
        mem[k] = cfg_wdata;
    end
  end
endmodule
`default_nettype wire

// ==== apw_apb_cfg_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module apw_apb_cfg_bench import apw_pkg::*;;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [DATA_W-1:0] pwd = '0;
  logic [11:0] lat = 12'h005;
  logic pready, pslverr, req, wr, ack;
  logic [DATA_W-1:0] prd;
  logic [WADDR_W-1:0] caddr;
  logic [WIDE_W-1:0] cwd, crd;
  // last answer seen and its wait in cycles
  logic [DATA_W-1:0] rd;
  logic err;
  int cyc;
  int n_fail = 0;
  int n_tests = 0;
  always #12.5 core_clk = ~core_clk;
  apw_apb_cfg u_apw_apb_cfg (.core_clk(core_clk), .resetn(resetn),
    .apb_paddr(paddr), .apb_psel(psel), .apb_penable(pen),
    .apb_pwrite(pwr), .apb_pwdata(pwd), .apb_pready(pready),
    .apb_prdata(prd), .apb_pslverr(pslverr), .cfg_req(req),
    .cfg_write(wr), .cfg_addr(caddr), .cfg_wdata(cwd), .cfg_ack(ack),
    .cfg_rdata(crd));
  apw_core_model u_apw_core_model (.core_clk(core_clk), .resetn(resetn),
    .cfg_req(req), .cfg_write(wr), .cfg_addr(caddr), .cfg_wdata(cwd),
    .lat(lat), .cfg_ack(ack), .cfg_rdata(crd));
  // compare and count
  task automatic chk(input string what, input logic [WIDE_W-1:0] e,
                     input logic [WIDE_W-1:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  // counts and verdict
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // byte address from shadow flag and word address
  function automatic logic [ADDR_W-1:0] ba(input logic s,
                                           input logic [WADDR_W-1:0] w);
    return {s, w, 2'b00};
  endfunction
  // one transfer, held until the edge that sees pready high
  task automatic xfer(input logic [ADDR_W-1:0] a, input logic w,
                      input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    paddr <= a;
    pwr <= w;
    pwd <= d;
    psel <= 1'b1;
    @(posedge core_clk);
    pen <= 1'b1;
    cyc = 0;
    do
    begin
      @(negedge core_clk);
      cyc++;
      if (cyc > 1100)
      begin
        n_fail++;
        $display("ERROR pready expected 1 seen 0");
        end_sim();
      end
    end while (pready !== 1'b1);
    rd = prd;
    err = pslverr;
    @(posedge core_clk);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // read and judge data and error
  task automatic rchk(input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] e, input logic ee);
    xfer(a, 1'b0, '0);
    chk("prdata", e, rd);
    chk("pslverr", ee, err);
  endtask
  // outputs idle after reset
  task automatic t_reset;
    chk("pready", 1'b0, pready);
    chk("cfg_req", 1'b0, req);
    chk("pslverr", 1'b0, pslverr);
    $display("test reset done");
  endtask
  // reset in mid-run clears the bank 1 shadow buffer
  task automatic t_mid_reset;
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(negedge core_clk);
    chk("pready", 1'b0, pready);
    chk("cfg_req", 1'b0, req);
    rchk(ba(1'b1, 17'h08405), 32'h0, 1'b0);
    $display("test mid reset done");
  endtask
  // narrow access, byte offsets ignored, slow core
  task automatic t_narrow;
    xfer(ba(1'b0, 17'h00010) | 20'h3, 1'b1, 32'hcafe0001);
    chk("entry", {96'h0, 32'hcafe0001},
        u_apw_core_model.peek(17'h00010));
    rchk(ba(1'b0, 17'h00010) | 20'h1, 32'hcafe0001, 1'b0);
    lat <= 12'h03c;
    rchk(ba(1'b0, 17'h00010), 32'hcafe0001, 1'b0);
    chk("slow wait", 1'b1, cyc > 60);
    lat <= 12'h005;
    $display("test narrow done");
  endtask
  // wide write via shadow, captured read, overwrite of core update
  task automatic t_wide;
    for (int i = 0; i < 3; i++)
      xfer(ba(1'b1, 17'h08004 + 17'(i)), 1'b1,
           32'h11110000 + 32'(i));
    chk("shadow wait", 1, cyc);
    chk("untouched", '0, u_apw_core_model.peek(17'h08004));
    xfer(ba(1'b0, 17'h08007), 1'b1, 32'h11110003);
    chk("commit", {32'h11110003, 32'h11110002, 32'h11110001, 32'h11110000},
        u_apw_core_model.peek(17'h08004));
    u_apw_core_model.poke(17'h08400, {4{32'h5a5a5a5a}});
    rchk(ba(1'b0, 17'h08004), 32'h11110000, 1'b0);
    u_apw_core_model.poke(17'h08004, {4{32'hffffffff}});
    rchk(ba(1'b0, 17'h08400), 32'h5a5a5a5a, 1'b0);
    for (int i = 1; i < 4; i++)
      rchk(ba(1'b1, 17'h08004 + 17'(i)), 32'h11110000 + 32'(i), 1'b0);
    rchk(ba(1'b1, 17'h08402), 32'h5a5a5a5a, 1'b0);
    xfer(ba(1'b0, 17'h08007), 1'b1, 32'h77770003);
    chk("overwrite", {32'h77770003, 32'h11110002, 32'h11110001,
        32'h11110000}, u_apw_core_model.peek(17'h08004));
    $display("test wide done");
  endtask
  // unmapped, shadow outside banks, core too slow
  task automatic t_tmo;
    rchk(ba(1'b0, 17'h00800), 32'h0, 1'b1);
    chk("timeout", 1'b1, cyc >= 1024 && cyc <= 1026);
    rchk(ba(1'b1, 17'h00010), 32'h0, 1'b1);
    lat <= 12'h7d0;
    rchk(ba(1'b0, 17'h00010), 32'h0, 1'b1);
    lat <= 12'h005;
    rchk(ba(1'b0, 17'h00010), 32'hcafe0001, 1'b0);
    $display("test timeout done");
  endtask
  // main sequence
  initial
  begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    @(negedge core_clk);
    t_reset();
    t_narrow();
    t_wide();
    t_mid_reset();
    t_tmo();
    end_sim();
  end
endmodule
`default_nettype wire
